// ===== verilog/fault_readback.sv
// Fault flag snapshot loader and serial readback path
`timescale 1ns/100ps
// What this block does
// - No refresh: load flags at strobe fall
// - Top bit one at write: no load
// - Refresh: load flags at counter wrap
// - After load, block until one shift
// - Same data rewritten: display same, flags reloaded
// - One flag bit out per shift edge
// - Short flags 672-719, open 720-767
// - Capture flags at 33rd grayscale clock, masked
// - Refresh: transfer at 65,536th grayscale clock
module fault_readback #(
    parameter int GS_PERIOD = fault_readback_pkg::GS_PERIOD_DEFAULT
) (
    // System clock and control
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Serial link
    input wire logic shift_clk_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    // Pins from the display controller
    input wire logic latch_strobe_i,
    input wire logic grayscale_clock_i,
    input wire logic auto_refresh_enable_i,
    // Fault comparators and output state
    input fault_readback_pkg::fault_flags_t fault_flags_i,
    input wire logic [fault_readback_pkg::FLAG_COUNT-1:0] sink_output_n_on_i,
    // Status
    output logic gs_latch_load_o,
    output fault_readback_pkg::fault_flags_t fault_status_snapshot_o,
    output logic load_pending_o
);
    import fault_readback_pkg::*;

    localparam logic [GS_CNT_W-1:0] GS_LAST = GS_CNT_W'(GS_PERIOD - 1);
    localparam logic [GS_CNT_W-1:0] GS_CAPTURE = GS_CNT_W'(FLAG_CAPTURE_EDGE - 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic latch_s1_reg, latch_s2_reg, latch_d_reg;
    logic grayscale_clock_s1_reg, grayscale_clock_s2_reg, grayscale_clock_d_reg;
    logic refresh_s1_reg, refresh_s2_reg;
    logic top_s1_reg, top_s2_reg;
    logic ack_s1_reg, ack_s2_reg;
    fault_flags_t flags_s1_reg, flags_s2_reg;
    logic [FLAG_COUNT-1:0] on_s1_reg, on_s2_reg;
    logic top_bit_reg;
    logic ack_tgl_reg;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            latch_s1_reg <= 1'b0;
            latch_s2_reg <= 1'b0;
            latch_d_reg <= 1'b0;
            grayscale_clock_s1_reg <= 1'b0;
            grayscale_clock_s2_reg <= 1'b0;
            grayscale_clock_d_reg <= 1'b0;
            refresh_s1_reg <= 1'b0;
            refresh_s2_reg <= 1'b0;
            top_s1_reg <= 1'b0;
            top_s2_reg <= 1'b0;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            flags_s1_reg <= FLAGS_RESET;
            flags_s2_reg <= FLAGS_RESET;
            on_s1_reg <= 48'h0;
            on_s2_reg <= 48'h0;
        end else if (ce_i) begin
            latch_s1_reg <= latch_strobe_i;
            latch_s2_reg <= latch_s1_reg;
            latch_d_reg <= latch_s2_reg;
            grayscale_clock_s1_reg <= grayscale_clock_i;
            grayscale_clock_s2_reg <= grayscale_clock_s1_reg;
            grayscale_clock_d_reg <= grayscale_clock_s2_reg;
            refresh_s1_reg <= auto_refresh_enable_i;
            refresh_s2_reg <= refresh_s1_reg;
            top_s1_reg <= top_bit_reg;
            top_s2_reg <= top_s1_reg;
            ack_s1_reg <= ack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
            flags_s1_reg <= fault_flags_i;
            flags_s2_reg <= flags_s1_reg;
            on_s1_reg <= sink_output_n_on_i;
            on_s2_reg <= on_s1_reg;
        end
    end

    logic latch_rise, latch_fall, grayscale_clock_rise, gs_write;
    assign latch_rise = latch_s2_reg & ~latch_d_reg;
    assign latch_fall = ~latch_s2_reg & latch_d_reg;
    assign grayscale_clock_rise = grayscale_clock_s2_reg & ~grayscale_clock_d_reg;
    assign gs_write = latch_rise & ~top_s2_reg;

    // ------------------------------------------------------------
    // Grayscale counter and flag latch
    // ------------------------------------------------------------
    logic [GS_CNT_W-1:0] gs_cnt_reg;
    logic gs_wrap;
    assign gs_wrap = grayscale_clock_rise && (gs_cnt_reg == GS_LAST);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            gs_cnt_reg <= GS_CNT_RESET;
        end else if (ce_i) begin
            if (gs_write) begin
                gs_cnt_reg <= GS_CNT_RESET;
            end else if (gs_wrap) begin
                gs_cnt_reg <= GS_CNT_RESET;
            end else if (grayscale_clock_rise) begin
                gs_cnt_reg <= gs_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fault_status_snapshot_o <= FLAGS_RESET;
        end else if (ce_i && grayscale_clock_rise && gs_cnt_reg == GS_CAPTURE) begin
            fault_status_snapshot_o.open_fault_flag <= flags_s2_reg.open_fault_flag & on_s2_reg;
            fault_status_snapshot_o.short_fault_flag <= flags_s2_reg.short_fault_flag & on_s2_reg;
        end
    end

    // ------------------------------------------------------------
    // Load sequencing
    // ------------------------------------------------------------
    load_state_t state_reg;
    logic req_tgl_reg;
    logic load_req;
    fault_flags_t pend_flags_reg;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_reg <= ST_IDLE;
        end else if (ce_i) begin
            if (gs_write) begin
                state_reg <= refresh_s2_reg ? ST_WAIT_WRAP : ST_WAIT_FALL;
            end else begin
                unique case (state_reg)
                    ST_IDLE: state_reg <= ST_IDLE;
                    ST_WAIT_FALL: begin
                        if (latch_fall) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_WAIT_WRAP: begin
                        if (gs_wrap) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    assign load_req = ((state_reg == ST_WAIT_FALL) && latch_fall && !gs_write)
        || ((state_reg == ST_WAIT_WRAP) && gs_wrap && !gs_write);
    assign load_pending_o = req_tgl_reg ^ ack_s2_reg;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            gs_latch_load_o <= 1'b0;
        end else if (ce_i) begin
            gs_latch_load_o <= (gs_write && !refresh_s2_reg)
                || ((state_reg == ST_WAIT_WRAP) && gs_wrap && !gs_write);
        end else begin
            gs_latch_load_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            req_tgl_reg <= 1'b0;
            pend_flags_reg <= FLAGS_RESET;
        end else if (ce_i && load_req && !load_pending_o) begin
            req_tgl_reg <= ~req_tgl_reg;
            pend_flags_reg <= fault_status_snapshot_o;
        end
    end

    // ------------------------------------------------------------
    // Shift clock domain
    // ------------------------------------------------------------
    logic rst_l1_reg, rst_l2_reg;
    logic load_now;
    logic [SHIFT_LEN-1:0] shift_reg;
    logic [SHIFT_LEN-1:0] loaded;

    always_ff @(posedge shift_clk_i) begin
        rst_l1_reg <= srst_i;
        rst_l2_reg <= rst_l1_reg;
    end

    // Request and flags stand still through the controller wait, so read directly;
    // a shift clock that stops between frames could never clock a sync stage
    assign load_now = req_tgl_reg != ack_tgl_reg;

    always_comb begin
        loaded = shift_reg;
        loaded[SHORT_LSB +: FLAG_COUNT] = pend_flags_reg.short_fault_flag;
        loaded[OPEN_LSB +: FLAG_COUNT] = pend_flags_reg.open_fault_flag;
    end

    // Load merges with the first shift; controller holds off until then
    always_ff @(posedge shift_clk_i) begin
        if (rst_l2_reg) begin
            shift_reg <= SHIFT_RESET;
            ack_tgl_reg <= 1'b0;
        end else if (load_now) begin
            shift_reg <= {loaded[TOP_BIT-1:0], serial_data_in_i};
            ack_tgl_reg <= req_tgl_reg;
        end else begin
            shift_reg <= {shift_reg[TOP_BIT-1:0], serial_data_in_i};
        end
    end

    assign serial_data_out_o = shift_reg[TOP_BIT];
    assign top_bit_reg = shift_reg[TOP_BIT];

endmodule : fault_readback

// ===== common/fault_readback_pkg.sv
// Constants and types for the fault status readback block
package fault_readback_pkg;

    // ------------------------------------------------------------
    // Shift register layout
    // ------------------------------------------------------------
    localparam int SHIFT_LEN = 769;
    localparam int TOP_BIT = 768;
    localparam int FLAG_COUNT = 48;
    localparam int SHORT_LSB = 672;
    localparam int OPEN_LSB = 720;
    localparam logic [SHIFT_LEN-1:0] SHIFT_RESET = {SHIFT_LEN{1'b0}};

    // ------------------------------------------------------------
    // Grayscale timing
    // ------------------------------------------------------------
    localparam int GS_CNT_W = 16;
    localparam int GS_PERIOD_DEFAULT = 65536;
    localparam int FLAG_CAPTURE_EDGE = 33;
    localparam logic [GS_CNT_W-1:0] GS_CNT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [FLAG_COUNT-1:0] open_fault_flag;
        logic [FLAG_COUNT-1:0] short_fault_flag;
    } fault_flags_t;

    localparam fault_flags_t FLAGS_RESET = '{open_fault_flag: 48'h0, short_fault_flag: 48'h0};

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT_FALL = 3'h2,
        ST_WAIT_WRAP = 3'h4
    } load_state_t;

endpackage : fault_readback_pkg

// ===== bench/fault_readback_asserts.sv
// Checker for the fault status readback block
`timescale 1ns/100ps
module fault_readback_asserts
    import fault_readback_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic latch_strobe_i,
    input wire logic grayscale_clock_i,
    input wire logic auto_refresh_enable_i,
    input wire logic [FLAG_COUNT-1:0] sink_output_n_on_i,
    input wire logic gs_latch_load_o,
    input fault_flags_t fault_status_snapshot_o,
    input wire logic load_pending_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    sequence strobe_rose;
        $past(latch_strobe_i, 3) && !$past(latch_strobe_i, 8);
    endsequence
    a_load_single: assert property (gs_latch_load_o |=> !gs_latch_load_o)
        else $error("load pulse too long");
    a_load_cause: assert property (gs_latch_load_o && !auto_refresh_enable_i |-> strobe_rose)
        else $error("load without strobe rise");
    a_pend_cause: assert property ($rose(load_pending_o) && !auto_refresh_enable_i |-> !$past(latch_strobe_i, 2))
        else $error("flag load before strobe fall");
    a_wrap_pend: assert property (gs_latch_load_o && auto_refresh_enable_i |-> ##[0:3] load_pending_o)
        else $error("no flag load at wrap");
    a_pend_stays: assert property ($rose(load_pending_o) |=> load_pending_o)
        else $error("pending load lost");
    a_snap_edge: assert property ($changed(fault_status_snapshot_o) |-> $past(grayscale_clock_i, 3))
        else $error("snapshot off grayscale edge");
    a_mask_open: assert property ((fault_status_snapshot_o.open_fault_flag & ~sink_output_n_on_i) == '0)
        else $error("open flag of off output");
    a_mask_short: assert property ((fault_status_snapshot_o.short_fault_flag & ~sink_output_n_on_i) == '0)
        else $error("short flag of off output");
    a_reset_clear: assert property ($fell(srst_i) |-> !gs_latch_load_o && !load_pending_o
        && fault_status_snapshot_o == FLAGS_RESET) else $error("state after reset");
endmodule : fault_readback_asserts
bind fault_readback fault_readback_asserts chk (.ref_clk_i, .srst_i, .latch_strobe_i, .grayscale_clock_i,
    .auto_refresh_enable_i, .sink_output_n_on_i, .gs_latch_load_o, .fault_status_snapshot_o, .load_pending_o);

// ===== bench/fault_controller_model.sv
// Display controller model driving the link and strobe pins
`timescale 1ns/100ps
module fault_controller_model (
    // Toward the block
    output logic shift_clk_o,
    output logic serial_o,
    output logic latch_strobe_o,
    output logic grayscale_clock_o,
    // From the block
    input wire logic serial_data_out_i
);
    initial begin
        shift_clk_o = 1'b0;
        serial_o = 1'b0;
        latch_strobe_o = 1'b0;
        grayscale_clock_o = 1'b0;
    end
    task automatic gs(input int n);
        repeat (n) begin
            #20 grayscale_clock_o = 1'b1;
            #20 grayscale_clock_o = 1'b0;
        end
    endtask : gs
    // Write strobe, then wait period plus six clocks
    task automatic pulse();
        latch_strobe_o = 1'b1;
        gs(40);
        latch_strobe_o = 1'b0;
        gs(30);
    endtask : pulse
    task automatic burst();
        repeat (4) begin
            #3 shift_clk_o = 1'b1;
            #3 shift_clk_o = 1'b0;
        end
    endtask : burst
    // Frame MSB first, output sampled before each rise
    task automatic frame(input logic [768:0] d, output logic [768:0] q);
        for (int k = 768; k >= 0; k--) begin
            serial_o = d[k];
            q[k] = serial_data_out_i;
            #3 shift_clk_o = 1'b1;
            #3 shift_clk_o = 1'b0;
        end
        serial_o = ~serial_o;
    endtask : frame
endmodule : fault_controller_model

// ===== bench/fault_readback_bench.sv
// Testbench for the fault status readback block
`timescale 1ns/100ps
module fault_readback_bench;
    import fault_readback_pkg::*;
    typedef struct packed {logic refr; logic top;} row_t;
    row_t rows [4] = '{'{1'b0, 1'b0}, '{1'b0, 1'b1}, '{1'b1, 1'b0}, '{1'b1, 1'b1}};
    logic clk, srst, ce, sclk, sdi, sdo, lat, grayscale_clock, refr, gsl, pend;
    fault_flags_t flags, snap;
    logic [47:0] son;
    logic [768:0] w, nw, got, ex;
    int num_errors = 0;
    int tests_run = 0;
    int loads, i;
    fault_readback #(.GS_PERIOD(64)) uut (.ref_clk_i(clk), .srst_i(srst), .ce_i(ce), .shift_clk_i(sclk),
        .serial_data_in_i(sdi), .serial_data_out_o(sdo), .latch_strobe_i(lat), .grayscale_clock_i(grayscale_clock),
        .auto_refresh_enable_i(refr), .fault_flags_i(flags), .sink_output_n_on_i(son),
        .gs_latch_load_o(gsl), .fault_status_snapshot_o(snap), .load_pending_o(pend));
    fault_controller_model ctl (.shift_clk_o(sclk), .serial_o(sdi), .latch_strobe_o(lat),
        .grayscale_clock_o(grayscale_clock), .serial_data_out_i(sdo));
    task automatic chk(input string n, input logic [768:0] e, input logic [768:0] s);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic test_done();
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        loads += int'(gsl === 1'b1);
    end
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        refr = 1'b0;
        flags = 96'hF00F_1234_5678_9ABC_DEF0_0FF1;
        son = 48'hFFF0_FFF0_FFFF;
        w = {1'b0, {24{32'hA5C3_0F1E}}};
        fork
            ctl.burst();
        join_none
        repeat (4) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        ctl.frame(w, got);
        for (int r = 0; r < 4; r++) begin
            @(negedge clk);
            refr = rows[r].refr;
            loads = 0;
            ctl.pulse();
            for (i = 0; i < 50 && pend !== 1'b1 && !rows[r].top; i++) @(negedge clk);
            if (i == 50) begin
                num_errors++;
                test_done();
            end
            chk("load pulses", 769'(!rows[r].top), 769'(loads));
            ex = rows[r].top ? w : {w[768], flags & {son, son}, w[671:0]};
            nw = {r < 3 && rows[(r + 1) % 4].top, ~w[767:0]};
            ctl.frame(nw, got);
            chk("readback", ex, got);
            w = nw;
        end
        ctl.frame(w, got);
        chk("resend", w, got);
        @(negedge clk);
        refr = 1'b0;
        loads = 0;
        ctl.pulse();
        flags = ~flags;
        ctl.pulse();
        chk("reload pulses", 769'(2), 769'(loads));
        chk("snapshot", 769'(flags & {son, son}), 769'(snap));
        ctl.frame(w, got);
        chk("reread", {w[768], ~flags & {son, son}, w[671:0]}, got);
        @(negedge clk);
        ce = 1'b0;
        loads = 0;
        ctl.pulse();
        ce = 1'b1;
        repeat (4) @(negedge clk);
        chk("frozen", 769'(0), 769'({pend, loads}));
        @(negedge clk);
        srst = 1'b1;
        ctl.burst();
        @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk("after reset", 769'(0), 769'({sdo, pend, gsl, snap}));
        test_done();
    end
endmodule : fault_readback_bench
